// >>> pkg/tws_pkg.sv
// Package for the two-wire slave task, event and interrupt registers.
// Assumes a 32-bit APB with word-aligned byte addresses.
package tws_pkg;
  localparam logic [11:0] OFF_ARM_RX = 12'h030;
  localparam logic [11:0] OFF_ARM_TX = 12'h034;
  localparam logic [11:0] OFF_EV_STOPPED = 12'h104;
  localparam logic [11:0] OFF_EV_ERROR = 12'h124;
  localparam logic [11:0] OFF_EV_RX_BEGUN = 12'h14c;
  localparam logic [11:0] OFF_EV_TX_BEGUN = 12'h150;
  localparam logic [11:0] OFF_EV_WRITE = 12'h164;
  localparam logic [11:0] OFF_EV_READ = 12'h168;
  localparam logic [11:0] OFF_LINKS = 12'h200;
  localparam logic [11:0] OFF_IRQ_EN = 12'h300;
  localparam logic [11:0] OFF_IRQ_SET = 12'h304;
  localparam logic [11:0] OFF_IRQ_CLR = 12'h308;
  localparam logic [11:0] OFF_ERR_CAUSE = 12'h4d0;
  localparam logic [11:0] OFF_MATCH = 12'h4d4;
  localparam logic [11:0] OFF_ENABLE = 12'h500;
  // Event bit positions in the interrupt registers
  localparam int BIT_STOPPED = 1;
  localparam int BIT_ERROR = 9;
  localparam int BIT_RX_BEGUN = 19;
  localparam int BIT_TX_BEGUN = 20;
  localparam int BIT_WRITE = 25;
  localparam int BIT_READ = 26;
  localparam logic [31:0] IRQ_MASK = 32'h0618_0202;
  // Link bits and error cause bits
  localparam int BIT_WR_SUSPEND = 0;
  localparam int BIT_RD_SUSPEND = 1;
  localparam int BIT_OVERFLOW = 0;
  localparam int BIT_DATA_REFUSED = 2;
  localparam int BIT_TX_EXHAUSTED = 3;
  localparam logic [31:0] ERR_MASK = 32'h0000_000d;
  localparam logic [3:0] ENABLE_WIDTH_BITS = 4'hf;
  localparam logic [3:0] ENABLE_ON = 4'h9;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // Event pulses coming from the protocol engine
  typedef struct packed {
    logic stopped;
    logic error;
    logic rx_begun;
    logic tx_begun;
    logic write_cmd;
    logic read_cmd;
  } tws_events_t;

  // Error cause pulses from the protocol engine
  typedef struct packed {
    logic overflow;
    logic data_refused;
    logic tx_exhausted;
  } tws_errs_t;
endpackage : tws_pkg

// >>> rtl/tws_regs.sv
// Task, event, shortcut and interrupt registers of a two-wire slave.
// Assumes an APB master on the same clock and a protocol engine
// that pulses events for one cycle and consumes task strobes.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Writing one to arm-receive task arms slave for next write command.
// - Writing one to arm-transmit task arms slave for next read command.
// - Link bit 0 set: write-command event triggers suspend; clear: never.
// - Link bit 1 set: read-command event triggers suspend; both reset off.
// - Enable register holds bits 1,9,19,20,25,26 per event, reset off.
// - Clearer write ones clears enables; reading returns enable state.
// - Error cause bit 0 set on blocked receive overflow.
// - Error cause bit 2 set when a data byte is refused.
// - Error cause bit 3 set when transmit buffer over-read is blocked.
// - Match register bit 0 reports which address matched; resets zero.
// - Stopped event raised when a transaction ends by stop or task.
// - Bytes beyond receive limit are discarded, refused, raise error.
module tws_regs
  import tws_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Protocol engine side
  input wire tws_events_t events_in,
  input wire tws_errs_t errs_in,
  input wire logic match_valid_in,
  input wire logic match_index_in,
  output logic arm_rx_out,
  output logic arm_tx_out,
  output logic suspend_out,
  output logic enable_out,
  // Interrupt
  output logic irq_out
);

  // Zero-wait-state slave; decode is combinational
  wire logic wr_acc = psel_in & penable_in & pwrite_in;
  wire logic rd_acc = psel_in & penable_in & ~pwrite_in;
  wire logic wr_one = pwdata_in[0];

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction : hit

  // Event flags in register order
  localparam int NEV = 6;
  localparam logic [11:0] EV_OFF [NEV] = '{OFF_EV_STOPPED, OFF_EV_ERROR,
    OFF_EV_RX_BEGUN, OFF_EV_TX_BEGUN, OFF_EV_WRITE, OFF_EV_READ};
  localparam int EV_BIT [NEV] = '{BIT_STOPPED, BIT_ERROR, BIT_RX_BEGUN,
    BIT_TX_BEGUN, BIT_WRITE, BIT_READ};
  wire logic [NEV-1:0] ev_pulse = {events_in.read_cmd, events_in.write_cmd,
    events_in.tx_begun, events_in.rx_begun, events_in.error,
    events_in.stopped};

  logic [NEV-1:0] ev_q;
  logic [31:0] ev_vec;
  logic [31:0] irq_en_q;
  logic [1:0] links_q;
  logic [31:0] err_q;
  logic match_q;
  logic [3:0] enable_q;
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;

  genvar g;
  generate
    for (g = 0; g < NEV; g++) begin : g_ev
      // Hardware set wins over a software clear in the same cycle
      always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
          ev_q[g] <= 1'b0;
        end else if (ev_pulse[g]) begin
          ev_q[g] <= 1'b1;
        end else if (wr_acc && hit(paddr_in, EV_OFF[g])) begin
          ev_q[g] <= wr_one;
        end
      end
      ev_set_a: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        ev_pulse[g] |=> ev_q[g])
        else $error("event flag not set");
      ev_clr_a: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        wr_acc && hit(paddr_in, EV_OFF[g]) && !wr_one && !ev_pulse[g]
        |=> !ev_q[g])
        else $error("event flag not cleared");
      // Only a write to its own register may drop a flag
      ev_hold_a: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        ev_q[g] && !(wr_acc && hit(paddr_in, EV_OFF[g]))
        |=> ev_q[g])
        else $error("event flag lost");
      ev_irq_a: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        ev_q[g] && irq_en_q[EV_BIT[g]] |-> irq_out)
        else $error("enabled event gives no interrupt");
    end
  endgenerate

  ev_sticky_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    events_in.stopped |=> ev_q[0])
    else $error("stopped flag not set");

  always_comb begin
    ev_vec = '0;
    for (int i = 0; i < NEV; i++) begin
      ev_vec[EV_BIT[i]] = ev_q[i];
    end
  end

  // Tasks are one-cycle strobes; writing zero does nothing
  assign arm_rx_out = wr_acc & hit(paddr_in, OFF_ARM_RX) & wr_one;
  assign arm_tx_out = wr_acc & hit(paddr_in, OFF_ARM_TX) & wr_one;
  arm_rx_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    arm_rx_out |-> wr_acc && paddr_in == OFF_ARM_RX && pwdata_in[0])
    else $error("arm receive without write of one");
  arm_tx_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    wr_acc && paddr_in == OFF_ARM_TX && pwdata_in[0] |-> arm_tx_out)
    else $error("arm transmit missed");
  task_zero_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    wr_acc && !wr_one |-> !arm_rx_out && !arm_tx_out)
    else $error("task fired on a zero write");

  // Shortcut fires in the event's own cycle
  assign suspend_out =
    (links_q[BIT_WR_SUSPEND] & events_in.write_cmd) |
    (links_q[BIT_RD_SUSPEND] & events_in.read_cmd);
  // A read command in the same cycle may raise suspend on its own
  wr_suspend_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    events_in.write_cmd && !events_in.read_cmd |->
    suspend_out == links_q[BIT_WR_SUSPEND])
    else $error("write shortcut mismatch");
  rd_suspend_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    events_in.read_cmd && links_q[BIT_RD_SUSPEND] |-> suspend_out)
    else $error("read shortcut missing");
  no_spur_susp_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    !events_in.read_cmd && !events_in.write_cmd |-> !suspend_out)
    else $error("spurious suspend");

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      links_q <= 2'h0;
    end else if (wr_acc && hit(paddr_in, OFF_LINKS)) begin
      links_q <= pwdata_in[1:0];
    end
  end
  links_write_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    wr_acc && hit(paddr_in, OFF_LINKS) |=> links_q == $past(pwdata_in[1:0]))
    else $error("shortcut bits not written");

  wire logic [31:0] en_wmask = IRQ_MASK & pwdata_in;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      irq_en_q <= REG_RESET;
    end else if (wr_acc && hit(paddr_in, OFF_IRQ_EN)) begin
      irq_en_q <= en_wmask;
    end else if (wr_acc && hit(paddr_in, OFF_IRQ_SET)) begin
      irq_en_q <= irq_en_q | en_wmask;
    end else if (wr_acc && hit(paddr_in, OFF_IRQ_CLR)) begin
      irq_en_q <= irq_en_q & ~en_wmask;
    end
  end
  irq_set_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    wr_acc && paddr_in == OFF_IRQ_SET && pwdata_in[BIT_ERROR]
    |=> irq_en_q[BIT_ERROR])
    else $error("enable set failed");
  irq_clr_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    wr_acc && paddr_in == OFF_IRQ_CLR && pwdata_in[BIT_READ]
    |=> !irq_en_q[BIT_READ])
    else $error("enable clear failed");
  // Bits without an event must never latch, whatever software writes
  en_mask_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    (irq_en_q & ~IRQ_MASK) == 32'h0)
    else $error("enable bit outside event set");
  en_write_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    wr_acc && hit(paddr_in, OFF_IRQ_EN) |=> irq_en_q == $past(en_wmask))
    else $error("enable write lost");
  set_zero_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    wr_acc && hit(paddr_in, OFF_IRQ_SET) && pwdata_in == 32'h0
    |=> $stable(irq_en_q))
    else $error("zero write to setter changed enables");
  clr_zero_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    wr_acc && hit(paddr_in, OFF_IRQ_CLR) && pwdata_in == 32'h0
    |=> $stable(irq_en_q))
    else $error("zero write to clearer changed enables");

  // Error causes: engine sets, software writes ones to clear
  wire logic [31:0] err_set = {28'h0, errs_in.tx_exhausted,
    errs_in.data_refused, 1'b0, errs_in.overflow};
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      err_q <= REG_RESET;
    end else if (wr_acc && hit(paddr_in, OFF_ERR_CAUSE)) begin
      err_q <= (err_q & ~(pwdata_in & ERR_MASK)) | err_set;
    end else begin
      err_q <= err_q | err_set;
    end
  end
  err_refused_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    errs_in.data_refused |=> err_q[BIT_DATA_REFUSED])
    else $error("refused byte cause missing");
  err_over_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    errs_in.overflow |=> err_q[BIT_OVERFLOW])
    else $error("overflow cause missing");
  err_exh_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    errs_in.tx_exhausted |=> err_q[BIT_TX_EXHAUSTED])
    else $error("over-read cause missing");
  err_clr_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    wr_acc && hit(paddr_in, OFF_ERR_CAUSE) &&
    pwdata_in[BIT_DATA_REFUSED] && !errs_in.data_refused
    |=> !err_q[BIT_DATA_REFUSED])
    else $error("error cause not cleared");
  err_rsvd_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    (err_q & ~ERR_MASK) == 32'h0)
    else $error("error cause outside defined bits");

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      match_q <= 1'b0;
    end else if (match_valid_in) begin
      match_q <= match_index_in;
    end
  end
  match_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    match_valid_in |=> match_q == $past(match_index_in))
    else $error("match status stale");
  // The index wire wanders between matches; status must not follow it
  match_hold_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    !match_valid_in |=> $stable(match_q))
    else $error("match status moved without a match");

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      enable_q <= 4'h0;
    end else if (wr_acc && hit(paddr_in, OFF_ENABLE)) begin
      enable_q <= pwdata_in[3:0];
    end
  end
  // Only the enabled code turns the slave on
  assign enable_out = (enable_q == ENABLE_ON);
  en_on_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    wr_acc && hit(paddr_in, OFF_ENABLE)
    |=> enable_out == ($past(pwdata_in[3:0]) == ENABLE_ON))
    else $error("enable code not decoded");

  // Level interrupt from flags gated by enables
  assign irq_out = |(ev_vec & irq_en_q);
  irq_line_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    ev_q[1] && irq_en_q[BIT_ERROR] |-> irq_out)
    else $error("interrupt not raised");
  irq_quiet_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    irq_en_q == 32'h0 |-> !irq_out)
    else $error("interrupt with all enables off");

  // Read mux; task registers and unmapped offsets read zero
  always_comb begin
    rdata_d = '0;
    case (paddr_in)
      OFF_EV_STOPPED: rdata_d = {31'h0, ev_q[0]};
      OFF_EV_ERROR: rdata_d = {31'h0, ev_q[1]};
      OFF_EV_RX_BEGUN: rdata_d = {31'h0, ev_q[2]};
      OFF_EV_TX_BEGUN: rdata_d = {31'h0, ev_q[3]};
      OFF_EV_WRITE: rdata_d = {31'h0, ev_q[4]};
      OFF_EV_READ: rdata_d = {31'h0, ev_q[5]};
      OFF_LINKS: rdata_d = {30'h0, links_q};
      OFF_IRQ_EN, OFF_IRQ_SET, OFF_IRQ_CLR: rdata_d = irq_en_q;
      OFF_ERR_CAUSE: rdata_d = err_q;
      OFF_MATCH: rdata_d = {31'h0, match_q};
      OFF_ENABLE: rdata_d = {28'h0, enable_q};
      default: rdata_d = '0;
    endcase
  end

  // Data output from a flop, loaded during setup phase
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      prdata_q <= REG_RESET;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      prdata_q <= rdata_d;
    end
  end
  assign prdata_out = prdata_q;
  assign pready_out = 1'b1;
  assign pslverr_out = 1'b0;

  // Read data must not move between setup and access
  rd_stable_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    rd_acc && $past(psel_in && !penable_in)
    |-> prdata_out == $past(rdata_d))
    else $error("read data moved during access");
  pready_a: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    psel_in && penable_in |-> pready_out && !pslverr_out)
    else $error("access not answered cleanly");
  reset_vals_a: assert property (@(posedge sys_clk_in)
    rst_in |=> irq_en_q == REG_RESET && links_q == 2'h0 && !match_q &&
    err_q == REG_RESET && ev_q == '0 && !enable_out)
    else $error("register not cleared by reset");

  // Main scenarios
  cv_susp_c: cover property (@(posedge sys_clk_in) suspend_out);
  cv_irq_c: cover property (@(posedge sys_clk_in) $rose(irq_out));
  cv_arm_c: cover property (@(posedge sys_clk_in) arm_rx_out ##[1:20]
    events_in.rx_begun);
  cv_err_c: cover property (@(posedge sys_clk_in) errs_in.tx_exhausted);
  cv_match_c: cover property (@(posedge sys_clk_in) match_valid_in);

endmodule : tws_regs
`default_nettype wire

// >>> dv/tws_engine_model.sv
// Behavioural protocol engine: turns bench requests into one-cycle pulses.
// Assumes the register block samples the pulses on the rising edge.
`timescale 1ns/1ns
`default_nettype none
module tws_engine_model
  import tws_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Requests from bench
  input wire tws_events_t ev_req_in,
  input wire tws_errs_t err_req_in,
  input wire logic match_req_in,
  input wire logic match_idx_in,
  // Pulses to the register block
  output var tws_events_t events_out,
  output var tws_errs_t errs_out,
  output logic match_valid_out,
  output logic match_index_out
);
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      events_out <= '0;
      errs_out <= '0;
      match_valid_out <= 1'b0;
      match_index_out <= 1'b0;
    end else begin
      events_out <= ev_req_in;
      events_out.error <= ev_req_in.error | (|err_req_in);
      errs_out <= err_req_in;
      match_valid_out <= match_req_in;
      // Index means nothing without valid, so keep it moving
      match_index_out <= match_req_in ? match_idx_in : ~match_index_out;
    end
  end
endmodule : tws_engine_model
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the two-wire slave register block.
// Assumes APB answers within sixteen cycles and one-cycle engine pulses.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import tws_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0;
  logic [31:0] prdata_out, rd, wv;
  logic pready_out, pslverr_out, arm_rx_out, arm_tx_out, suspend_out;
  logic enable_out, irq_out, match_valid_in, match_index_in, arx, atx, sus;
  tws_events_t events_in, ev_req = '0;
  tws_errs_t errs_in, err_req = '0;
  logic m_req = 1'b0;
  logic m_idx = 1'b0;
  int bad_count = 0;
  int total_checks = 0;
  int en_m, err_m, i;
  int ev_m[6];
  logic [11:0] ev_off[6] = '{OFF_EV_STOPPED, OFF_EV_ERROR, OFF_EV_RX_BEGUN,
    OFF_EV_TX_BEGUN, OFF_EV_WRITE, OFF_EV_READ};
  int ev_bit[6] = '{BIT_STOPPED, BIT_ERROR, BIT_RX_BEGUN, BIT_TX_BEGUN,
    BIT_WRITE, BIT_READ};
  logic [11:0] regs[10] = '{OFF_ARM_RX, OFF_ARM_TX, OFF_LINKS, OFF_IRQ_EN,
    OFF_IRQ_SET, OFF_IRQ_CLR, OFF_ERR_CAUSE, OFF_MATCH, OFF_ENABLE, 12'h7fc};
  always #50 sys_clk_in = ~sys_clk_in;
  tws_regs u_tws_regs(.sys_clk_in, .rst_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
    .pslverr_out, .events_in, .errs_in, .match_valid_in, .match_index_in,
    .arm_rx_out, .arm_tx_out, .suspend_out, .enable_out, .irq_out);
  tws_engine_model u_tws_engine_model(.sys_clk_in, .rst_in,
    .ev_req_in(ev_req), .err_req_in(err_req), .match_req_in(m_req),
    .match_idx_in(m_idx), .events_out(events_in), .errs_out(errs_in),
    .match_valid_out(match_valid_in), .match_index_out(match_index_in));
  task automatic wrap_up;
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge sys_clk_in);
      if (pready_out === 1'b1) break;
    end
    if (n == 16) begin
      bad_count++;
      wrap_up();
    end
    rd = prdata_out;
    arx = arm_rx_out;
    atx = arm_tx_out;
    chk(pslverr_out, 1'b0);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task automatic fire(input tws_events_t e, input tws_errs_t x);
    @(posedge sys_clk_in);
    ev_req <= e;
    err_req <= x;
    @(posedge sys_clk_in);
    ev_req <= '0;
    err_req <= '0;
    @(negedge sys_clk_in);
    sus = suspend_out;
    for (int k = 0; k < 6; k++) begin
      if (e[5 - k] || (k == 1 && |x)) ev_m[k] = 1;
    end
    err_m |= {x.tx_exhausted, x.data_refused, 1'b0, x.overflow};
  endtask : fire
  function automatic logic irq_exp();
    irq_exp = 1'b0;
    for (int k = 0; k < 6; k++) begin
      if (ev_m[k] != 0 && en_m[ev_bit[k]]) irq_exp = 1'b1;
    end
  endfunction : irq_exp
  initial begin
    void'($urandom(32'h325a));
    en_m = 0;
    err_m = 0;
    ev_m = '{0, 0, 0, 0, 0, 0};
    repeat (3) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    foreach (regs[k]) begin
      apb(1'b0, regs[k], '0);
      chk(rd, 32'h0);
    end
    apb(1'b1, OFF_ARM_RX, 32'h1);
    chk({arx, atx}, 2'b10);
    apb(1'b1, OFF_ARM_TX, 32'h1);
    chk({arx, atx}, 2'b01);
    apb(1'b1, OFF_ARM_RX, 32'h0);
    chk({arx, atx}, 2'b00);
    for (i = 0; i < 2; i++) begin
      wv = $urandom();
      apb(1'b1, i ? OFF_IRQ_CLR : OFF_IRQ_SET, wv);
      en_m = i ? en_m & ~(wv & IRQ_MASK) : en_m | (wv & IRQ_MASK);
      apb(1'b1, i ? OFF_IRQ_CLR : OFF_IRQ_SET, 32'h0);
      apb(1'b0, i ? OFF_IRQ_CLR : OFF_IRQ_SET, '0);
      chk(rd, en_m);
    end
    apb(1'b1, OFF_IRQ_EN, 32'hffff_ffff);
    en_m = IRQ_MASK;
    apb(1'b0, OFF_IRQ_EN, '0);
    chk(rd, en_m);
    for (i = 0; i < 6; i++) begin
      fire(6'b100000 >> i, '0);
      apb(1'b0, ev_off[i], '0);
      chk(rd, ev_m[i]);
      chk(irq_out, irq_exp());
      apb(1'b1, ev_off[i], 32'h0);
      ev_m[i] = 0;
      apb(1'b0, ev_off[i], '0);
      chk({rd[30:0], irq_out}, {31'h0, irq_exp()});
    end
    for (i = 0; i < 4; i++) begin
      apb(1'b1, OFF_LINKS, i);
      fire(6'b000010, '0);
      chk(sus, i % 2);
      fire(6'b000001, '0);
      chk(sus, i / 2);
    end
    apb(1'b1, OFF_IRQ_CLR, 32'h0600_0000);
    en_m = en_m & ~32'h0600_0000;
    @(negedge sys_clk_in);
    chk(irq_out, irq_exp());
    for (i = 0; i < 3; i++) begin
      fire('0, 3'b100 >> i);
      apb(1'b0, OFF_ERR_CAUSE, '0);
      chk(rd, err_m);
      apb(1'b0, OFF_EV_ERROR, '0);
      chk(rd, ev_m[1]);
    end
    apb(1'b1, OFF_ERR_CAUSE, ERR_MASK);
    err_m = 0;
    apb(1'b0, OFF_ERR_CAUSE, '0);
    chk(rd, err_m);
    for (i = 1; i >= 0; i--) begin
      @(posedge sys_clk_in);
      m_req <= 1'b1;
      m_idx <= i[0];
      @(posedge sys_clk_in);
      m_req <= 1'b0;
      apb(1'b0, OFF_MATCH, '0);
      chk(rd, i);
      wv = i ? 32'h9 : $urandom_range(8, 0);
      apb(1'b1, OFF_ENABLE, wv);
      apb(1'b0, OFF_ENABLE, '0);
      chk({rd[30:0], enable_out}, {wv[30:0], wv == 32'h9});
    end
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
